/* src/odtr_map.svh */
// Constants for the OAM delay time stamp rewriter
// How it works
// - Ingress 1DM for own MEP requests an 8-byte write at its offset.
// - Ingress 1DM stamp is captured time minus latency correction.
// - Egress 1DM forward transmit stamp is captured time plus correction.
// - A write places the stamp at the offset, then the FCS is recomputed.
// - Ingress DMM for own MEP gets forward receive stamp, time minus correction.
// - Ingress delay reply gets backward receive stamp, time minus correction.
// - Egress delay reply gets backward transmit stamp, time plus correction.
// - Egress DMM gets forward transmit stamp, time plus correction.
// - A preloaded time enters the counter at the next sync pulse rise with the strobe set to load.
// - Fine adjust moves the time one nanosecond per request.
// - The save strobe captures current time into a readable saved stamp.
// - After a programmable clock count, one extra nanosecond is added.
// - Sync input takes 1 pps, slower periodic, or one-shot pulses.
// - Frames not matched pass through byte for byte.
// - Strobe either loads a pending value or saves current time.
`ifndef ODTR_MAP_SVH
`define ODTR_MAP_SVH
`define ODTR_CLK_PERIOD_NS 4
`define ODTR_NS_STEP       32'(`ODTR_CLK_PERIOD_NS)
`define ODTR_NS_PER_SEC    32'h3B9ACA00
`define ODTR_FINE_NS       32'h00000001
`define ODTR_TS_BYTES      16'h0008
`define ODTR_FCS_BYTES     16'h0004
`define ODTR_CRC_INIT      32'hFFFFFFFF
`define ODTR_CRC_POLY      32'hEDB88320
`define ODTR_FIFO_DEPTH    8
`define ODTR_FIFO_WIDTH    10
`endif

/* src/odtr_pkg.sv */
// Types for the OAM delay time stamp rewriter
package odtr_pkg;
  typedef enum logic [1:0]
  {
    ODTR_KIND_NONE,
    ODTR_KIND_1DM,
    ODTR_KIND_DMM,
    ODTR_KIND_DMR
  } odtr_kind_t;
endpackage : odtr_pkg

/* src/odtr_fifo.sv */
// Small valid/ready FIFO in the frame data path
`timescale 1ns/1ps
module odtr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             room_q;
  logic             push;
  logic             pop;

  assign in_ready  = room_q;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && room_q;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      room_q <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q  <= cnt_q + 1'b1;
        room_q <= cnt_q != (AW+1)'(DEPTH - 1);
      end
      else if (pop && !push)
      begin
        cnt_q  <= cnt_q - 1'b1;
        room_q <= 1'b1;
      end
    end
  end
endmodule : odtr_fifo

/* src/odtr_rewriter.sv */
// Time stamp rewriter and local time counter
`timescale 1ns/1ps
`include "odtr_map.svh"
module odtr_rewriter
  import odtr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        path_egress,
  input  wire logic [31:0] lat_corr_ns,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_valid,
  input  wire logic        in_sof,
  input  wire logic        in_eof,
  output logic             in_ready,
  input  wire odtr_kind_t  cls_kind,
  input  wire logic        cls_own_mep,
  input  wire logic [15:0] cls_offset,
  input  wire logic [15:0] cls_len,
  output logic [7:0]       out_data_q,
  output logic             out_valid_q,
  output logic             out_sof_q,
  output logic             out_eof_q,
  input  wire logic        out_ready,
  input  wire logic        sync_pin,
  input  wire logic        strobe_load,
  input  wire logic [31:0] load_sec,
  input  wire logic [31:0] load_ns,
  input  wire logic        load_arm,
  input  wire logic        adj_inc,
  input  wire logic        adj_dec,
  input  wire logic [31:0] auto_period,
  output logic [31:0]      tod_sec_q,
  output logic [31:0]      tod_ns_q,
  output logic [31:0]      saved_sec_q,
  output logic [31:0]      saved_ns_q,
  output logic             load_pend_q
);
  // ----------------------------------------
  // Local time counter
  // ----------------------------------------
  logic        sync_q;
  logic        sync_rise;
  logic [31:0] auto_cnt_q;
  logic        auto_fire;
  logic [32:0] ns_sum;

  assign sync_rise = sync_pin && !sync_q;
  assign auto_fire = (auto_period != '0) && (auto_cnt_q >= auto_period - 32'h1);
  assign ns_sum = {1'b0, tod_ns_q} + {1'b0, `ODTR_NS_STEP}
                + ((adj_inc || auto_fire) ? {1'b0, `ODTR_FINE_NS} : 33'h0)
                + (auto_fire && adj_inc ? {1'b0, `ODTR_FINE_NS} : 33'h0)
                - (adj_dec ? {1'b0, `ODTR_FINE_NS} : 33'h0);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_q <= 1'b0;
    end
    else
    begin
      sync_q <= sync_pin;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || auto_fire)
    begin
      auto_cnt_q <= '0;
    end
    else if (auto_period != '0)
    begin
      auto_cnt_q <= auto_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      load_pend_q <= 1'b0;
    end
    else if (load_arm)
    begin
      load_pend_q <= 1'b1;
    end
    else if (sync_rise && strobe_load)
    begin
      load_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tod_sec_q <= '0;
      tod_ns_q  <= '0;
    end
    else if (sync_rise && strobe_load && load_pend_q)
    begin
      tod_sec_q <= load_sec;
      tod_ns_q  <= load_ns;
    end
    else if (ns_sum >= {1'b0, `ODTR_NS_PER_SEC})
    begin
      tod_sec_q <= tod_sec_q + 32'h1;
      tod_ns_q  <= 32'(ns_sum - {1'b0, `ODTR_NS_PER_SEC});
    end
    else
    begin
      tod_ns_q <= ns_sum[31:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      saved_sec_q <= '0;
      saved_ns_q  <= '0;
    end
    else if (sync_rise && !strobe_load)
    begin
      saved_sec_q <= tod_sec_q;
      saved_ns_q  <= tod_ns_q;
    end
  end

  // ----------------------------------------
  // Capture and correction at frame start
  // ----------------------------------------
  logic        sof_in;
  logic        hit;
  logic [31:0] cor_sec;
  logic [31:0] cor_ns;
  logic [32:0] add_ns;
  logic        pend_wr_q;
  logic [31:0] pend_sec_q;
  logic [31:0] pend_ns_q;
  logic [15:0] pend_off_q;
  logic [15:0] pend_len_q;

  assign sof_in = in_valid && in_ready && in_sof;
  assign hit    = (cls_kind != ODTR_KIND_NONE) && cls_own_mep;
  assign add_ns = {1'b0, tod_ns_q} + {1'b0, lat_corr_ns};

  always_comb
  begin
    cor_sec = tod_sec_q;
    cor_ns  = tod_ns_q;
    if (path_egress)
    begin
      if (add_ns >= {1'b0, `ODTR_NS_PER_SEC})
      begin
        cor_sec = tod_sec_q + 32'h1;
        cor_ns  = 32'(add_ns - {1'b0, `ODTR_NS_PER_SEC});
      end
      else
      begin
        cor_ns = add_ns[31:0];
      end
    end
    else if (tod_ns_q >= lat_corr_ns)
    begin
      cor_ns = tod_ns_q - lat_corr_ns;
    end
    else
    begin
      cor_sec = tod_sec_q - 32'h1;
      cor_ns  = tod_ns_q + `ODTR_NS_PER_SEC - lat_corr_ns;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pend_wr_q  <= 1'b0;
      pend_sec_q <= '0;
      pend_ns_q  <= '0;
      pend_off_q <= '0;
      pend_len_q <= '0;
    end
    else if (sof_in)
    begin
      pend_wr_q  <= hit;
      pend_sec_q <= cor_sec;
      pend_ns_q  <= cor_ns;
      pend_off_q <= cls_offset;
      pend_len_q <= cls_len;
    end
  end

  // ----------------------------------------
  // Delay buffer
  // ----------------------------------------
  logic [9:0] f_word;
  logic       f_valid;
  logic       pop;

  assign pop = f_valid && (!out_valid_q || out_ready);

  odtr_fifo #(
    .WIDTH (`ODTR_FIFO_WIDTH),
    .DEPTH (`ODTR_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   ({in_sof, in_eof, in_data}),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_data  (f_word),
    .out_valid (f_valid),
    .out_ready (pop)
  );

  // ----------------------------------------
  // Field write and FCS regeneration
  // ----------------------------------------
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `ODTR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd

  logic        act_wr_q;
  logic [63:0] act_ts_q;
  logic [15:0] act_off_q;
  logic [15:0] act_len_q;
  logic [15:0] idx_q;
  logic [31:0] crc_q;
  logic        w_wr;
  logic [63:0] w_ts;
  logic [15:0] w_off;
  logic [15:0] w_len;
  logic [15:0] b_idx;
  logic [15:0] rel;
  logic [15:0] fcs_pos;
  logic        in_field;
  logic        in_fcs;
  logic [7:0]  o_byte;
  logic [31:0] crc_base;

  assign w_wr     = f_word[9] ? pend_wr_q : act_wr_q;
  assign w_ts     = f_word[9] ? {pend_sec_q, pend_ns_q} : act_ts_q;
  assign w_off    = f_word[9] ? pend_off_q : act_off_q;
  assign w_len    = f_word[9] ? pend_len_q : act_len_q;
  assign b_idx    = f_word[9] ? 16'h0 : idx_q;
  assign rel      = b_idx - w_off;
  assign fcs_pos  = w_len - `ODTR_FCS_BYTES;
  assign in_field = (b_idx >= w_off) && (rel < `ODTR_TS_BYTES);
  assign in_fcs   = (w_len >= `ODTR_FCS_BYTES) && (b_idx >= fcs_pos);
  assign crc_base = f_word[9] ? `ODTR_CRC_INIT : crc_q;

  always_comb
  begin
    o_byte = f_word[7:0];
    if (w_wr && in_fcs)
    begin
      o_byte = ~crc_q[8*2'(b_idx - fcs_pos) +: 8];
    end
    else if (w_wr && in_field)
    begin
      o_byte = w_ts[8*(7-rel[2:0]) +: 8];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      act_wr_q  <= 1'b0;
      act_ts_q  <= '0;
      act_off_q <= '0;
      act_len_q <= '0;
      idx_q     <= '0;
      crc_q     <= `ODTR_CRC_INIT;
    end
    else if (pop)
    begin
      act_wr_q  <= w_wr;
      act_ts_q  <= w_ts;
      act_off_q <= w_off;
      act_len_q <= w_len;
      idx_q     <= b_idx + 16'h1;
      if (!in_fcs)
      begin
        crc_q <= crc_upd(crc_base, o_byte);
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
      out_sof_q   <= 1'b0;
      out_eof_q   <= 1'b0;
    end
    else if (pop)
    begin
      out_valid_q <= 1'b1;
      out_data_q  <= o_byte;
      out_sof_q   <= f_word[9];
      out_eof_q   <= f_word[8];
    end
    else if (out_ready)
    begin
      out_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_ing_sub;
    @(posedge ref_clk) disable iff (sys_rst)
    sof_in && hit && !path_egress && lat_corr_ns < `ODTR_NS_PER_SEC |=>
      (pend_wr_q && (pend_ns_q + $past(lat_corr_ns) == $past(tod_ns_q)
        || pend_ns_q + $past(lat_corr_ns) == $past(tod_ns_q) + `ODTR_NS_PER_SEC));
  endproperty
  a_ing_sub : assert property (p_ing_sub) else $error("ingress stamp wrong");

  property p_egr_add;
    @(posedge ref_clk) disable iff (sys_rst)
    sof_in && hit && path_egress && lat_corr_ns < `ODTR_NS_PER_SEC |=>
      (pend_ns_q == $past(tod_ns_q) + $past(lat_corr_ns)
        || pend_ns_q + `ODTR_NS_PER_SEC == $past(tod_ns_q) + $past(lat_corr_ns));
  endproperty
  a_egr_add : assert property (p_egr_add) else $error("egress stamp wrong");

  property p_foreign;
    @(posedge ref_clk) disable iff (sys_rst)
    sof_in && !cls_own_mep |=> !pend_wr_q;
  endproperty
  a_foreign : assert property (p_foreign) else $error("foreign MEP stamped");

  property p_first_byte;
    @(posedge ref_clk) disable iff (sys_rst)
    pop && w_wr && b_idx == w_off && !in_fcs |=> out_data_q == $past(w_ts[63:56]);
  endproperty
  a_first_byte : assert property (p_first_byte) else $error("seconds MSB not first");

  property p_pass;
    @(posedge ref_clk) disable iff (sys_rst)
    pop && !w_wr |=> out_data_q == $past(f_word[7:0]);
  endproperty
  a_pass : assert property (p_pass) else $error("unmatched byte altered");

  property p_fcs;
    @(posedge ref_clk) disable iff (sys_rst)
    pop && w_wr && in_fcs && b_idx == fcs_pos |=> out_data_q == ~$past(crc_q[7:0]);
  endproperty
  a_fcs : assert property (p_fcs) else $error("FCS not regenerated");

  property p_fine;
    @(posedge ref_clk) disable iff (sys_rst)
    adj_inc && !adj_dec && !auto_fire && !sync_rise && tod_ns_q < 32'h3B9AC000
      |=> tod_ns_q == $past(tod_ns_q) + `ODTR_NS_STEP + `ODTR_FINE_NS;
  endproperty
  a_fine : assert property (p_fine) else $error("fine adjust not one ns");

  property p_auto;
    @(posedge ref_clk) disable iff (sys_rst)
    auto_fire && !adj_inc && !adj_dec && !sync_rise && tod_ns_q < 32'h3B9AC000
      |=> tod_ns_q == $past(tod_ns_q) + `ODTR_NS_STEP + `ODTR_FINE_NS;
  endproperty
  a_auto : assert property (p_auto) else $error("auto correction missing");

  property p_load;
    @(posedge ref_clk) disable iff (sys_rst)
    sync_rise && strobe_load && load_pend_q |=> tod_sec_q == $past(load_sec)
      && tod_ns_q == $past(load_ns) && load_pend_q == $past(load_arm);
  endproperty
  a_load : assert property (p_load) else $error("preload not applied");

  property p_save;
    @(posedge ref_clk) disable iff (sys_rst)
    sync_rise && !strobe_load |=> saved_ns_q == $past(tod_ns_q)
      && saved_sec_q == $past(tod_sec_q) ##1 $stable(saved_ns_q)
      || $rose(sync_pin);
  endproperty
  a_save : assert property (p_save) else $error("save capture wrong");
endmodule : odtr_rewriter

/* test/odtr_line_sink.sv */
// Line-side sink model that stalls on request and records the output stream
`timescale 1ns/1ps
module odtr_line_sink
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] out_data_q,
  input  wire logic       out_valid_q,
  input  wire logic       out_sof_q,
  input  wire logic       out_eof_q,
  input  wire logic       halt,
  output logic            out_ready
);
  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  logic [9:0] rx_q[$];
  always @(posedge ref_clk)
  begin
    out_ready <= !sys_rst && !halt;
    if (out_valid_q && out_ready)
    begin
      rx_q.push_back({out_sof_q, out_eof_q, out_data_q});
    end
  end
endmodule : odtr_line_sink

/* test/oam_delay_timestamp_rewriter_bench.sv */
// Self-checking bench for the OAM delay time stamp rewriter
`timescale 1ns/1ps
`include "odtr_map.svh"
`define CHK(what, exp, got) \
  begin checks_done++; if ((exp) !== (got)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module oam_delay_timestamp_rewriter_bench
  import odtr_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        path_egress = 1'b0;
  logic [31:0] lat_corr_ns = 32'h0;
  logic [7:0]  in_data = 8'h00;
  logic        in_valid = 1'b0;
  logic        in_sof = 1'b0;
  logic        in_eof = 1'b0;
  logic        in_ready;
  odtr_kind_t  cls_kind = ODTR_KIND_NONE;
  logic        cls_own_mep = 1'b0;
  logic [15:0] cls_offset = 16'h0;
  logic [15:0] cls_len = 16'h0;
  logic [7:0]  out_data_q;
  logic        out_valid_q, out_sof_q, out_eof_q, out_ready;
  logic        sync_pin = 1'b0;
  logic        strobe_load = 1'b0;
  logic [31:0] load_sec = 32'h0;
  logic [31:0] load_ns = 32'h0;
  logic        load_arm = 1'b0;
  logic        adj_inc = 1'b0;
  logic        adj_dec = 1'b0;
  logic [31:0] auto_period = 32'h0;
  logic [31:0] tod_sec_q, tod_ns_q, saved_sec_q, saved_ns_q;
  logic        load_pend_q;
  logic        halt = 1'b1;
  logic        hold_all = 1'b0;
  logic [31:0] seed = 32'h0000BB0C;
  logic [31:0] tick = 32'h0;
  logic [31:0] t_base = 32'h0;
  logic [31:0] base_ns = 32'h0;
  logic [31:0] cap_ns = 32'h0;
  int          fails = 0;
  int          checks_done = 0;

  odtr_rewriter  u_odtr_rewriter (.*);
  odtr_line_sink u_odtr_line_sink (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic void add_fcs(ref logic [7:0] q[$]);
    logic [31:0] c;
    c = `ODTR_CRC_INIT;
    foreach (q[i])
    begin
      c ^= 32'(q[i]);
      repeat (8) c = c[0] ? ((c >> 1) ^ `ODTR_CRC_POLY) : (c >> 1);
    end
    c = ~c;
    for (int b = 0; b < 4; b++) q.push_back(c[8*b +: 8]);
  endfunction : add_fcs

  initial forever #2 ref_clk = ~ref_clk;

  // Line stalls at random; time model of the captured SOF stamp
  always @(posedge ref_clk)
  begin
    halt <= hold_all || (xs() % 4 == 0);
    tick <= tick + 1;
    if (in_valid && in_ready && in_sof) cap_ns <= base_ns + `ODTR_NS_STEP * (tick - t_base);
  end

  task automatic drift(int n, logic inc, logic dec, logic [31:0] gain);
    logic [31:0] a;
    @(posedge ref_clk);
    a = tod_ns_q;
    adj_inc <= inc;
    adj_dec <= dec;
    @(posedge ref_clk);
    adj_inc <= 1'b0;
    adj_dec <= 1'b0;
    repeat (n - 1) @(posedge ref_clk);
    `CHK("time drift", a + 32'(n * 4) + gain, tod_ns_q)
  endtask : drift

  task automatic sync_edge(logic ld);
    strobe_load <= ld;
    sync_pin <= 1'b1;
    @(posedge ref_clk);
    sync_pin <= 1'b0;
  endtask : sync_edge

  task automatic send_frame(logic eg, odtr_kind_t k, logic own, logic [31:0] corr);
    logic [7:0]  f[$];
    logic [7:0]  e[$];
    logic [15:0] len, off;
    logic [31:0] ns, sec;
    logic [63:0] st;
    logic [7:0]  sw;
    int          w;
    len = 16'h0014 + 16'(xs() % 24);
    off = 16'(xs() % (len - 12));
    for (int i = 0; i < len - 4; i++)
      f.push_back(8'(xs()));
    if (k == ODTR_KIND_DMR)
      for (int i = 0; i < 6; i++)
      begin
        sw = f[i];
        f[i] = f[i + 6];
        f[i + 6] = sw;
      end
    for (int b = 0; b < 8; b++)
      f[off + b] = 8'h00;
    add_fcs(f);
    u_odtr_line_sink.rx_q.delete();
    path_egress <= eg;
    lat_corr_ns <= corr;
    cls_kind <= k;
    cls_own_mep <= own;
    cls_offset <= off;
    cls_len <= len;
    foreach (f[i])
    begin
      in_data <= f[i];
      in_valid <= 1'b1;
      in_sof <= (i == 0);
      in_eof <= (i == len - 1);
      do @(posedge ref_clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    in_sof <= 1'b0;
    in_eof <= 1'b0;
    w = 0;
    while (u_odtr_line_sink.rx_q.size() < len && w < 300)
    begin
      @(posedge ref_clk);
      w++;
    end
    e = f;
    if (own && k != ODTR_KIND_NONE)
    begin
      sec = 32'h00001234;
      ns = eg ? cap_ns + corr : cap_ns - corr;
      if (eg && ns >= `ODTR_NS_PER_SEC)
      begin
        ns -= `ODTR_NS_PER_SEC;
        sec++;
      end
      else if (!eg && cap_ns < corr)
      begin
        ns += `ODTR_NS_PER_SEC;
        sec--;
      end
      st = {sec, ns};
      for (int b = 0; b < 8; b++) e[off + b] = st[63 - 8*b -: 8];
      repeat (4) void'(e.pop_back());
      add_fcs(e);
    end
    `CHK("frame length", 32'(len), u_odtr_line_sink.rx_q.size())
    foreach (e[i])
      `CHK("out byte", {1'(i == 0), 1'(i == len - 1), e[i]}, u_odtr_line_sink.rx_q[i])
  endtask : send_frame

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end

  initial
  begin
    logic [31:0] x;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("valid after reset", 1'b0, out_valid_q)
    `CHK("pending after reset", 1'b0, load_pend_q)
    drift(6, 1'b1, 1'b0, 32'h1);
    drift(6, 1'b0, 1'b1, 32'hFFFFFFFF);
    auto_period <= 32'h0000000A;
    repeat (25) @(posedge ref_clk);
    drift(10, 1'b0, 1'b0, 32'h1);
    auto_period <= 32'h0;
    $display("done: time adjust");
    load_sec <= 32'h00001234;
    load_ns <= 32'h00000100;
    load_arm <= 1'b1;
    @(posedge ref_clk);
    load_arm <= 1'b0;
    @(posedge ref_clk);
    `CHK("pending", 1'b1, load_pend_q)
    sync_edge(1'b1);
    @(posedge ref_clk);
    t_base = tick;
    base_ns = 32'h00000100;
    `CHK("loaded ns", 32'h00000100, tod_ns_q)
    `CHK("loaded sec", 32'h00001234, tod_sec_q)
    `CHK("pending cleared", 1'b0, load_pend_q)
    $display("done: load");
    for (int p = 0; p < 2; p++)
    begin
      repeat (3 + 40 * p) @(posedge ref_clk);
      x = base_ns + `ODTR_NS_STEP * (tick + 1 - t_base);
      sync_edge(1'b0);
      @(posedge ref_clk);
      `CHK("saved ns", x, saved_ns_q)
      `CHK("saved sec", 32'h00001234, saved_sec_q)
    end
    $display("done: save");
    hold_all <= 1'b1;
    fork
      send_frame(1'b1, ODTR_KIND_1DM, 1'b1, 32'h00000033);
    join_none
    repeat (30) @(posedge ref_clk);
    `CHK("refused when full", 1'b0, in_ready)
    hold_all <= 1'b0;
    wait fork;
    $display("done: fifo full");
    for (int eg = 0; eg < 2; eg++)
      for (int k = 1; k < 4; k++)
        send_frame(1'(eg), odtr_kind_t'(k), 1'b1, xs() % `ODTR_NS_PER_SEC);
    send_frame(1'b0, ODTR_KIND_DMM, 1'b0, 32'h00000200);
    send_frame(1'b1, ODTR_KIND_NONE, 1'b1, 32'h00000200);
    $display("done: frames");
    conclude();
  end
endmodule : oam_delay_timestamp_rewriter_bench
